// >>> wdw_defs.svh
// Constants for the windowed watchdog: register offsets, field positions,
// reset values and timing counts.
// Assumes inclusion by bare name from the package and the design file.
`ifndef WDW_DEFS_SVH
`define WDW_DEFS_SVH

// ****************************************************************
// Register byte offsets (Wishbone, one 32-bit word each)
// ****************************************************************
`define WDW_OFS_CONFIG      4'h0
`define WDW_OFS_RESET_CTRL  4'h4
`define WDW_OFS_CMD         4'h8
`define WDW_OFS_IRQ_STATUS  4'hC

// ****************************************************************
// Field positions
// ****************************************************************
`define WDW_CFG_POST_LSB    0
`define WDW_CFG_PRE_BIT     4
`define WDW_CFG_WIN_DIS_BIT 7
`define WDW_CFG_EN_LSB      8
`define WDW_CFG_WIN_LSB     10
`define WDW_RC_IDLE_BIT     2
`define WDW_RC_SLEEP_BIT    3
`define WDW_RC_TO_BIT       4
`define WDW_RC_SWEN_BIT     5
`define WDW_CMD_CLR_BIT     0
`define WDW_CMD_SLEEP_BIT   1
`define WDW_CMD_IDLE_BIT    2
`define WDW_CMD_SWITCH_BIT  3

// ****************************************************************
// Reset values
// ****************************************************************
`define WDW_CFG_RESET       12'h0FF
`define WDW_RC_RESET        6'h00

// ****************************************************************
// Timing: low-power RC tick at a nominal 32 kHz
// ****************************************************************
`define WDW_CLK_HZ          125000000
`define WDW_LOW_POWER_RC_OSC_HZ         32000
`define WDW_LOW_POWER_RC_OSC_DIV        (`WDW_CLK_HZ / `WDW_LOW_POWER_RC_OSC_HZ)
`define WDW_PRE_SHORT       32
`define WDW_PRE_LONG        128

`endif

// >>> wdw_pkg.sv
// Types shared by the windowed watchdog.
// Assumes the constant header sits in the same folder.
`include "wdw_defs.svh"

package wdw_pkg;

  // Configuration word as the fuse bits present it
  typedef struct packed {
    logic [1:0] window_size_select;
    logic [1:0] watchdog_enable_config;
    logic       window_mode_disable;
    logic [1:0] spare;
    logic       watchdog_prescale_select;
    logic [3:0] postscale_ratio_select;
  } wdw_cfg_type;

  // Power state of the core as seen by the watchdog
  typedef enum logic [1:0] {
    WDW_RUN,
    WDW_SLEEP,
    WDW_IDLE
  } wdw_pwr_type;

endpackage

// >>> wdw_watchdog.sv
// Windowed watchdog timer with a Wishbone classic slave.
// Assumes a single 125 MHz clock; the low-power RC time base is a
// divided tick of that clock, and a reset request loops back via rst_in.
//
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "wdw_defs.svh"

module wdw_watchdog
  import wdw_pkg::*;
#(
  parameter int LOW_POWER_RC_OSC_DIV = `WDW_LOW_POWER_RC_OSC_DIV
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [3:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  output logic             low_power_rc_osc_enable_out,
  output logic             wake_out,
  output logic             device_reset_out,
  output logic             irq_out
);

  // Elaboration check: a divider below two leaves no idle cycle
  // between ticks, which the prescaler compare relies on.
  if (LOW_POWER_RC_OSC_DIV < 2) begin : g_bad_div
    $error("LOW_POWER_RC_OSC_DIV must be at least 2");
  end

  // ****************************************************************
  // Register map
  // ****************************************************************
  // 0x0 configuration (stands in for the fuse word)
  //   [3:0]   postscale ratio select, ratio 2^N
  //   [4]     prescale select: 0 divides by 32, 1 by 128
  //   [7]     window mode disable; low arms the clear window
  //   [9:8]   enable config: 11 always on, 00 software control
  //   [11:10] window size select
  // 0x4 reset control
  //   [2]     idle status, [3] sleep status
  //   [4]     time-out flag, sticky
  //   [5]     software enable, cleared by rst_in
  // 0x8 command, write-only pulses; reads back the irq enable mask
  //   [0]     clear watchdog
  //   [1]     enter sleep, [2] enter idle (sleep wins if both)
  //   [3]     clock switch complete
  // 0xC interrupt status, write one to clear
  //   [0]     time-out, [1] wake
  //   [17:16] interrupt enable, written with byte lane 2
  // Writes need byte lane 0. A read answers one cycle after the
  // request; unaligned or unmapped offsets read zero.
  // Limitation: the status bits in reset control have no reset, so
  // they keep the cause of a watchdog reset; software defines them
  // with one write after power-up.
  // Limitation: one clock only; the RC time base tracks the system
  // clock, so its 32 kHz is nominal to the accuracy of LOW_POWER_RC_OSC_DIV.
  // Commands are single-cycle pulses taken with the bus request; a
  // power-save command while the watchdog is off still changes state.

  // ****************************************************************
  // Register state
  // ****************************************************************
  wdw_cfg_type cfg_r;
  logic        soft_en_r;
  logic        to_flag_r;
  logic        sleep_st_r;
  logic        idle_st_r;
  wdw_pwr_type pwr_r;
  logic [1:0]  irq_stat_r;
  logic [1:0]  irq_en_r;
  logic        ack_r;
  logic [31:0] rdat_r;

  logic [31:0] low_power_rc_osc_cnt_r;
  logic        low_power_rc_osc_tick;
  logic [6:0]  pre_cnt_r;
  logic        pre_tick;
  logic [14:0] post_cnt_r;
  logic        timeout;
  logic        wd_on;
  logic        cnt_clear;
  logic        in_window;

  logic        wb_go;
  logic        wr_cfg;
  logic        wr_rc;
  logic        wr_cmd;
  logic        wr_irq;
  logic        cmd_clr;
  logic        cmd_sleep;
  logic        cmd_idle;
  logic        cmd_switch;
  logic        clr_valid;
  logic        wake;
  logic [1:0]  irq_clr;

  // Postscaler terminal count: ratio 2^N, capped at 32768 for N=15
  function automatic logic [14:0] post_limit(input logic [3:0] sel);
    post_limit = 15'((32'h1 << sel) - 32'h1);
  endfunction

  // Write strobe for one register offset; byte lane 0 gates every register write
  function automatic logic reg_write(input logic go, input logic we, input logic lane0,
                                     input logic [3:0] adr, input logic [3:0] ofs);
    reg_write = go && we && lane0 && adr == ofs;
  endfunction

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  assign wb_go      = wb_cyc_in && wb_stb_in && !ack_r;
  // Decoded strobes last one cycle: the ack blocks a second take
  assign wr_cfg     = reg_write(wb_go, wb_we_in, wb_sel_in[0], wb_adr_in, `WDW_OFS_CONFIG);
  assign wr_rc      = reg_write(wb_go, wb_we_in, wb_sel_in[0], wb_adr_in, `WDW_OFS_RESET_CTRL);
  assign wr_cmd     = reg_write(wb_go, wb_we_in, wb_sel_in[0], wb_adr_in, `WDW_OFS_CMD);
  assign wr_irq     = reg_write(wb_go, wb_we_in, wb_sel_in[0], wb_adr_in, `WDW_OFS_IRQ_STATUS);
  assign cmd_clr    = wr_cmd && wb_dat_in[`WDW_CMD_CLR_BIT];
  assign cmd_sleep  = wr_cmd && wb_dat_in[`WDW_CMD_SLEEP_BIT];
  assign cmd_idle   = wr_cmd && wb_dat_in[`WDW_CMD_IDLE_BIT] && !cmd_sleep;
  assign cmd_switch = wr_cmd && wb_dat_in[`WDW_CMD_SWITCH_BIT];

  // Ack one cycle after the request, then drop for a cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_go;
    end
  end

  // Read data captured with the ack; unmapped offsets read zero
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdat_r <= 32'h0000_0000;
    end else if (wb_go && !wb_we_in) begin
      unique case (wb_adr_in)
        `WDW_OFS_CONFIG:     rdat_r <= {20'h00000, cfg_r};
        `WDW_OFS_RESET_CTRL: rdat_r <= {26'h0000000, soft_en_r, to_flag_r,
                                        sleep_st_r, idle_st_r, 2'h0};
        `WDW_OFS_CMD:        rdat_r <= {irq_en_r, 30'h00000000} >> 30;
        `WDW_OFS_IRQ_STATUS: rdat_r <= {30'h00000000, irq_stat_r};
        default:             rdat_r <= 32'h0000_0000;
      endcase
    end
  end
  assign wb_dat_out = rdat_r;
  assign wb_ack_out = ack_r;

  // ****************************************************************
  // Configuration word
  // ****************************************************************
  // Stands in for fuse bits; writable so a bench can choose modes
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_r <= wdw_cfg_type'(`WDW_CFG_RESET);
    end else if (wr_cfg) begin
      cfg_r <= wdw_cfg_type'(wb_dat_in[11:0]);
    end
  end

  // Interrupt enable mask, written at the upper half of the status word
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_en_r <= 2'h0;
    end else if (wr_irq && wb_sel_in[2]) begin
      irq_en_r <= wb_dat_in[17:16];
    end
  end

  // ****************************************************************
  // Enable decode and low-power RC time base
  // ****************************************************************
  assign wd_on = (cfg_r.watchdog_enable_config == 2'h3) ||
                 (cfg_r.watchdog_enable_config == 2'h0 && soft_en_r);
  assign low_power_rc_osc_enable_out = wd_on;

  // 32 kHz tick derived from the system clock
  // Trade-off: the tick phase is not cleared with the counts, so a
  // time-out may come up to one tick early after a clear.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      low_power_rc_osc_cnt_r <= 32'h0000_0000;
    end else if (!wd_on || low_power_rc_osc_cnt_r == 32'(LOW_POWER_RC_OSC_DIV - 1)) begin
      low_power_rc_osc_cnt_r <= 32'h0000_0000;
    end else begin
      low_power_rc_osc_cnt_r <= low_power_rc_osc_cnt_r + 32'h1;
    end
  end
  assign low_power_rc_osc_tick = wd_on && low_power_rc_osc_cnt_r == 32'(LOW_POWER_RC_OSC_DIV - 1);

  // ****************************************************************
  // Prescaler and postscaler
  // ****************************************************************
  // Window: the later quarter-fractions selected by window size
  // With ratio 1:1 the terminal count is zero, so every clear lands
  // inside the window; a useful window needs a postscaler of 1:4 or more.
  // The compare uses the live count, so a clear in the same cycle as
  // a postscaler step sees the value before the step.
  assign in_window = post_cnt_r >= 15'(({17'h0, post_limit(cfg_r.postscale_ratio_select)}
                     * (32'h3 - {30'h0, cfg_r.window_size_select})) >> 2);
  assign clr_valid = cmd_clr && (cfg_r.window_mode_disable || in_window);
  assign wake      = timeout && pwr_r != WDW_RUN;
  assign cnt_clear = clr_valid || cmd_sleep || cmd_idle || cmd_switch || wake;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pre_cnt_r <= 7'h00;
    end else if (cnt_clear || !wd_on) begin
      pre_cnt_r <= 7'h00;
    end else if (pre_tick) begin
      pre_cnt_r <= 7'h00;
    end else if (low_power_rc_osc_tick) begin
      pre_cnt_r <= pre_cnt_r + 7'h01;
    end
  end
  assign pre_tick = low_power_rc_osc_tick && pre_cnt_r == (cfg_r.watchdog_prescale_select ?
                    7'(`WDW_PRE_LONG - 1) : 7'(`WDW_PRE_SHORT - 1));

  // Counts regardless of power state
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      post_cnt_r <= 15'h0000;
    end else if (cnt_clear || !wd_on || timeout) begin
      post_cnt_r <= 15'h0000;
    end else if (pre_tick) begin
      post_cnt_r <= post_cnt_r + 15'h0001;
    end
  end
  assign timeout = pre_tick && post_cnt_r == post_limit(cfg_r.postscale_ratio_select);

  // ****************************************************************
  // Power state and wake
  // ****************************************************************
  // Sleep wins over idle written in the same word; a wake returns to
  // run and takes priority over a new entry.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pwr_r <= WDW_RUN;
    end else if (wake) begin
      pwr_r <= WDW_RUN;
    end else if (cmd_sleep) begin
      pwr_r <= WDW_SLEEP;
    end else if (cmd_idle) begin
      pwr_r <= WDW_IDLE;
    end
  end

  // Wake pulse; resumes the core, no reset
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wake_out <= 1'b0;
    end else begin
      wake_out <= wake;
    end
  end

  // Reset request on time-out while running; the system loops it into
  // rst_in, which clears counts, enable, interrupt status and bus state but keeps the reset control flags.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      device_reset_out <= 1'b0;
    end else begin
      device_reset_out <= timeout && pwr_r == WDW_RUN;
    end
  end

  // ****************************************************************
  // Reset control register
  // ****************************************************************
  // Status bits survive rst_in so software can see why it reset;
  // only the software enable is cleared there.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      soft_en_r <= 1'b0;
    end else if (wr_rc) begin
      soft_en_r <= wb_dat_in[`WDW_RC_SWEN_BIT];
    end
  end

  // Time-out flag: sticky, set wins over a software write of zero
  always_ff @(posedge clk_in) begin
    if (wr_rc) begin
      to_flag_r <= wb_dat_in[`WDW_RC_TO_BIT] || timeout;
    end else begin
      to_flag_r <= to_flag_r || timeout;
    end
  end

  // Sleep status: set on entry, left for software after a wake
  always_ff @(posedge clk_in) begin
    if (wr_rc) begin
      sleep_st_r <= wb_dat_in[`WDW_RC_SLEEP_BIT] || cmd_sleep;
    end else begin
      sleep_st_r <= sleep_st_r || cmd_sleep;
    end
  end

  // Idle status: set on entry, left for software after a wake
  always_ff @(posedge clk_in) begin
    if (wr_rc) begin
      idle_st_r <= wb_dat_in[`WDW_RC_IDLE_BIT] || cmd_idle;
    end else begin
      idle_st_r <= idle_st_r || cmd_idle;
    end
  end

  // ****************************************************************
  // Interrupts: bit0 time-out, bit1 wake; write-one-to-clear
  // ****************************************************************
  // Set wins over a write-one-to-clear in the same cycle, so no event is lost
  assign irq_clr = wr_irq ? wb_dat_in[1:0] : 2'h0;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_stat_r <= 2'h0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | {wake, timeout};
    end
  end
  assign irq_out = |(irq_stat_r & irq_en_r);

endmodule
`default_nettype wire

// >>> wdw_watchdog_props.sv
// Port checker for the windowed watchdog.
// Assumes binding to wdw_watchdog and the Wishbone timing of its note.
`timescale 1ns/10ps
`default_nettype none
`include "wdw_defs.svh"

module wdw_props (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [3:0]  wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        low_power_rc_osc_enable_out,
  input wire logic        wake_out,
  input wire logic        device_reset_out,
  input wire logic        irq_out
);
  // ****************************************************************
  // Bus and event checks
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  chk_ack_one_late: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack not one cycle after request");
  chk_ack_single: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack held");
  chk_unmapped_zero: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_we_in
    && wb_adr_in[1:0] != 2'h0 |=> wb_dat_out == 32'h0) else $error("unmapped read not zero");
  chk_forced_on: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out && wb_we_in &&
    wb_sel_in[0] && wb_adr_in == `WDW_OFS_CONFIG && wb_dat_in[9:8] == 2'h3 |=> low_power_rc_osc_enable_out)
    else $error("forced enable missing");
  chk_osc_runs: assert property (wake_out || device_reset_out |-> $past(low_power_rc_osc_enable_out))
    else $error("time-out without oscillator");
  chk_wake_xor_rst: assert property (!(wake_out && device_reset_out))
    else $error("wake and reset together");
  chk_wake_spacing: assert property (wake_out |=> (!wake_out && !device_reset_out)[*8])
    else $error("counts not cleared on wake");
  chk_rst_pulse: assert property (device_reset_out |=> !device_reset_out[*8])
    else $error("reset pulse repeats");
  chk_off_after_rst: assert property ($fell(rst_in) |-> !low_power_rc_osc_enable_out && !irq_out)
    else $error("enabled after reset");
endmodule

bind wdw_watchdog wdw_props wdw_props_i (.clk_in, .rst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
  .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .low_power_rc_osc_enable_out, .wake_out,
  .device_reset_out, .irq_out);
`default_nettype wire

// >>> wdw_watchdog_tb_top.sv
// Self-checking bench for the windowed watchdog.
// Assumes a shortened tick divider; the reset pulse is observed, not looped back.
`timescale 1ns/10ps
`default_nettype none
`include "wdw_defs.svh"

module wdw_watchdog_tb_top;
  localparam int DIV = 2;
  logic clk_in, rst_in, cyc, stb, we, ack, low_power_rc_osc, wake, dres, irq;
  logic [3:0] adr, sel;
  logic [31:0] dat, rd;
  int err_total = 0;
  int total_checks = 0;

  wdw_watchdog #(.LOW_POWER_RC_OSC_DIV(DIV)) wdw_watchdog_i (.clk_in(clk_in), .rst_in(rst_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(dat), .wb_dat_out(rd), .wb_ack_out(ack), .low_power_rc_osc_enable_out(low_power_rc_osc),
    .wake_out(wake), .device_reset_out(dres), .irq_out(irq));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic int period(input logic pre, input logic [3:0] post);
    return (DIV * (pre ? 128 : 32)) << post;
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Classic cycle: hold until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
    do begin
      @(posedge clk_in);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    q = rd;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic wait_ev(output int n);
    n = 0;
    while (dres !== 1'b1 && wake !== 1'b1 && n < 6000) begin
      @(posedge clk_in);
      n++;
    end
  endtask

  // Tick phase is not cleared, so allow a few cycles of slack
  task automatic in_range(input string name, input int n, input int p);
    check(name, (n >= p - 8 && n <= p + 4), 1);
  endtask

  task automatic give_verdict();
    if (err_total == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  initial begin
    #(8 * 80000);
    err_total++;
    give_verdict();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    logic [31:0] q;
    logic pre;
    logic [3:0] post;
    int n;
    rst_in = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 4'h0; sel = 4'h0; dat = 32'h0;
    void'($urandom(23));
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    wb(0, `WDW_OFS_CONFIG, 32'h0, q);
    check("config", q[11:0], `WDW_CFG_RESET);
    check("low_power_rc_osc_rst", low_power_rc_osc, 1'b0);
    wb(1, `WDW_OFS_RESET_CTRL, 32'h0, q);
    wb(0, 4'h1, 32'h0, q);
    check("unmapped", q, 32'h0);
    wb(1, `WDW_OFS_CONFIG, 32'h080, q);
    wb(1, `WDW_OFS_RESET_CTRL, 32'h20, q);
    check("low_power_rc_osc_sw", low_power_rc_osc, 1'b1);
    wb(1, `WDW_OFS_RESET_CTRL, 32'h0, q);
    check("low_power_rc_osc_off", low_power_rc_osc, 1'b0);
    for (int i = 0; i < 4; i++) begin
      pre = (i == 0) ? 1'b0 : 1'($urandom_range(1, 0));
      post = (i == 0) ? 4'h0 : 4'($urandom_range(3, 0));
      wb(1, `WDW_OFS_CONFIG, 32'h380 | {pre, 4'h0} | post, q);
      check("low_power_rc_osc_hw", low_power_rc_osc, 1'b1);
      wb(1, `WDW_OFS_CMD, (i[0] ? 32'h8 : 32'h1), q);
      repeat (20) @(posedge clk_in);
      check("early", dres, 1'b0);
      wb(1, `WDW_OFS_CMD, 32'h1, q);
      wait_ev(n);
      in_range("run_period", n, period(pre, post) - 3);
      check("run_reset", {dres, wake}, 2'b10);
      wb(0, `WDW_OFS_RESET_CTRL, 32'h0, q);
      check("flag_set", q[4], 1'b1);
      wb(1, `WDW_OFS_RESET_CTRL, 32'h0, q);
      wb(0, `WDW_OFS_RESET_CTRL, 32'h0, q);
      check("flag_clr", q[4], 1'b0);
    end
    wb(1, `WDW_OFS_CONFIG, 32'h380, q);
    for (int k = 1; k < 3; k++) begin
      wb(1, `WDW_OFS_CMD, 32'h1 << k, q);
      wait_ev(n);
      in_range("sleep_period", n, period(0, 0) - 2);
      check("wake", {dres, wake}, 2'b01);
      wb(0, `WDW_OFS_RESET_CTRL, 32'h0, q);
      check("pwr_flag", q[3:2], (k == 1) ? 2'b10 : 2'b01);
      wb(1, `WDW_OFS_RESET_CTRL, 32'h0, q);
    end
    wb(1, `WDW_OFS_CONFIG, 32'h080, q);
    check("irq_masked", irq, 1'b0);
    wb(0, `WDW_OFS_IRQ_STATUS, 32'h0, q);
    check("irq_status", q[1:0] != 2'h0, 1'b1);
    wb(1, `WDW_OFS_IRQ_STATUS, 32'h0003_0000, q);
    check("irq_on", irq, 1'b1);
    wb(1, `WDW_OFS_IRQ_STATUS, 32'h0003_0003, q);
    check("irq_clr", irq, 1'b0);
    wb(0, `WDW_OFS_CMD, 32'h0, q);
    check("irq_en", q[1:0], 2'h3);
    // Early clear in window mode must be ignored, a late one accepted
    wb(1, `WDW_OFS_CONFIG, 32'h304, q);
    wb(1, `WDW_OFS_CMD, 32'h8, q);
    repeat (10) @(posedge clk_in);
    wb(1, `WDW_OFS_CMD, 32'h1, q);
    wait_ev(n);
    in_range("win_ignore", n, period(0, 4) - 15);
    repeat (800) @(posedge clk_in);
    wb(1, `WDW_OFS_CMD, 32'h1, q);
    wait_ev(n);
    in_range("win_accept", n, period(0, 4) - 3);
    give_verdict();
  end
endmodule
`default_nettype wire
